// file: rtl/pipe_lane_phy.sv
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
// Overview of operation
// - De-emphasis input 0 gives 6 dB, 1 gives 3.5 dB at 5 Gbps.
// - Swing input 0 selects full swing, 1 selects half swing.
// - Polarity input high inverts the received data before decoding.
// - Receiver standby request 0 means active, 1 means standby; lane follows it.
// - Standby status output reports 0 active, 1 standby.
// - Transmit idle request holds the transmitter idle in every power state.
// - In P0 with idle low, MAC data and K flags are transmitted.
// - In P2 with idle low, a beacon is transmitted.
// - Coding sublayer resets asynchronously while its active-low reset is low.
// - Medium attachment resets asynchronously, independent of the coding sublayer reset.
// - Receive idle high on electrical idle; in P2 low means beacon seen.
// - Receive word is 40 bits in soft mode, else low 32 bits meaningful.
// - Earliest received byte sits in the lowest byte lane.
// - One K bit per byte, 0 data, 1 control; unused in soft mode.
// - Receive valid only with valid data and achieved symbol lock.
// - Status codes: 000 OK, 001 SKP added, 010 SKP removed, 011 detected.
// - Error codes: 100 code, 101 overflow, 110 underflow, 111 disparity.
// - Unclocked low-speed output mirrors the differential receiver input.
// - Two-bit power select picks P0, P0s, P1 or P2.
// - PHY status pulses on setup done, power change, rate change, detection.
module pipe_lane_phy import pipe_lane_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic coding_sublayer_reset_n,
  input wire logic medium_attach_reset_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire pipe_ctrl_t pipeCtrl,
  input wire logic [1:0] power_state_select,
  input wire logic [39:0] txData,
  input wire logic [3:0] txDataK,
  input wire logic [39:0] pmaRxWord,
  input wire logic cdrLock,
  input wire logic signalDetect,
  input wire logic beaconDetect,
  input wire logic farEndDetected,
  input wire eb_event_t ebEvent,
  input wire logic rxdP,
  input wire logic rxdN,
  output pma_drive_t pmaDrive,
  output logic [39:0] rxData,
  output logic [3:0] rxDataK,
  output logic rxValid,
  output logic [2:0] rxStatus,
  output logic rxElecIdle,
  output logic rxStandbyStatus,
  output logic phyStatus,
  output logic rxBypassData
);
  pipe_ctrl_t ctrl_reg;
  power_state_t pwr_reg;
  power_state_t pwrIn;
  logic setupDone_reg;
  logic [$clog2(SETUP_CYCLES + 1)-1:0] setupCnt_reg;
  logic detectBusy_reg;
  logic [$clog2(DETECT_CYCLES + 1)-1:0] detectCnt_reg;
  logic detectHit_reg;
  logic detectDone;
  logic setupEvent;
  logic pwrEvent;
  logic rateEvent;
  logic rdRun_reg;
  logic [2:0] errRun_reg;
  logic symLock_reg;
  logic symLock_next;
  logic softMode_reg;
  logic [15:0] errCnt_reg;
  logic errClear;
  logic [39:0] rxWord;
  logic [4:0] rdChain;
  logic [31:0] decBytes;
  logic [3:0] decK;
  logic [3:0] decCodeErr;
  logic [3:0] decDispErr;
  logic commaSeen;
  logic anyCodeErr;
  logic anyDispErr;
  logic rxPowered;
  logic [2:0] rxStatus_next;
  logic [31:0] statusWord;

  function automatic logic isAt(input logic [3:0] addr, input logic [3:0] ofs);
    return addr == ofs;
  endfunction

  assign pwrIn = power_state_t'(power_state_select);

  // Raw symbols are inverted ahead of the decoder so disparity tracking sees true polarity
  assign rxWord = ctrl_reg.rxPolarity ? ~pmaRxWord : pmaRxWord;
  assign rdChain[0] = rdRun_reg;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_dec
      sym_decoder_8b10b u_dec (
        .sym(rxWord[g*10 +: 10]),
        .rdIn(rdChain[g]),
        .dataByte(decBytes[g*8 +: 8]),
        .isK(decK[g]),
        .codeErr(decCodeErr[g]),
        .dispErr(decDispErr[g]),
        .rdOut(rdChain[g+1])
      );
    end
  endgenerate

  assign commaSeen = |(decK & {decBytes[31:24] == COMMA_BYTE, decBytes[23:16] == COMMA_BYTE,
                               decBytes[15:8] == COMMA_BYTE, decBytes[7:0] == COMMA_BYTE});
  assign anyCodeErr = |decCodeErr;
  assign anyDispErr = |decDispErr;
  // Receiver is powered only in P0 and P0s and while standby is not requested
  assign rxPowered = !ctrl_reg.rxStandby && (pwr_reg == PWR_P0 || pwr_reg == PWR_P0S);
  assign setupEvent = !setupDone_reg && setupCnt_reg == ($bits(setupCnt_reg))'(SETUP_CYCLES);
  assign pwrEvent = setupDone_reg && pwrIn != pwr_reg;
  assign rateEvent = setupDone_reg && pipeCtrl.rate != ctrl_reg.rate;
  assign detectDone = detectBusy_reg && detectCnt_reg == '0;
  assign errClear = write && !waitrequest && isAt(address, OFS_CTRL) && writedata[CTRL_CLR_BIT];

  // Low-speed bypass is deliberately combinational: it must not depend on any clock
  assign rxBypassData = rxdP & ~rxdN;

  always_comb begin
    symLock_next = symLock_reg;
    if (!cdrLock || !signalDetect || !rxPowered || errRun_reg == LOCK_LOSS_WORDS) begin
      symLock_next = 1'b0;
    end else if (commaSeen) begin
      symLock_next = 1'b1;
    end
  end

  always_comb begin
    if (detectDone) begin
      rxStatus_next = detectHit_reg ? RXST_DETECTED : RXST_OK;
    end else if (!symLock_next) begin
      rxStatus_next = RXST_OK;
    end else if (anyCodeErr) begin
      rxStatus_next = RXST_CODE_ERR;
    end else if (anyDispErr) begin
      rxStatus_next = RXST_DISP_ERR;
    end else if (ebEvent.overflow) begin
      rxStatus_next = RXST_OVERFLOW;
    end else if (ebEvent.underflow) begin
      rxStatus_next = RXST_UNDERFLOW;
    end else if (ebEvent.skpAdded) begin
      rxStatus_next = RXST_SKP_ADD;
    end else if (ebEvent.skpRemoved) begin
      rxStatus_next = RXST_SKP_REM;
    end else begin
      rxStatus_next = RXST_OK;
    end
  end

  // Control pins are captured once; only the power, rate and detect change checks also read the raw pins
  always_ff @(posedge clk_sys or negedge coding_sublayer_reset_n) begin
    if (!coding_sublayer_reset_n) begin
      ctrl_reg <= '0;
      pwr_reg <= PWR_P0;
    end else if (sys_rst) begin
      ctrl_reg <= '0;
      pwr_reg <= PWR_P0;
    end else begin
      ctrl_reg <= pipeCtrl;
      pwr_reg <= pwrIn;
    end
  end

  always_ff @(posedge clk_sys or negedge coding_sublayer_reset_n) begin
    if (!coding_sublayer_reset_n) begin
      setupDone_reg <= 1'b0;
      setupCnt_reg <= '0;
    end else if (sys_rst) begin
      setupDone_reg <= 1'b0;
      setupCnt_reg <= '0;
    end else if (!setupDone_reg) begin
      if (setupEvent) begin
        setupDone_reg <= 1'b1;
      end else begin
        setupCnt_reg <= setupCnt_reg + 1'b1;
      end
    end
  end

  // Receiver detection is only honoured in P1; in P0 the same pin would mean loopback
  always_ff @(posedge clk_sys or negedge coding_sublayer_reset_n) begin
    if (!coding_sublayer_reset_n) begin
      detectBusy_reg <= 1'b0;
      detectCnt_reg <= '0;
      detectHit_reg <= 1'b0;
    end else if (sys_rst) begin
      detectBusy_reg <= 1'b0;
      detectCnt_reg <= '0;
      detectHit_reg <= 1'b0;
    end else if (detectBusy_reg) begin
      if (detectDone) begin
        detectBusy_reg <= 1'b0;
      end else begin
        detectCnt_reg <= detectCnt_reg - 1'b1;
        detectHit_reg <= detectHit_reg | farEndDetected;
      end
    end else if (setupDone_reg && pwr_reg == PWR_P1 && pipeCtrl.txDetectRx && !ctrl_reg.txDetectRx) begin
      detectBusy_reg <= 1'b1;
      detectCnt_reg <= ($bits(detectCnt_reg))'(DETECT_CYCLES - 1);
      detectHit_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge coding_sublayer_reset_n) begin
    if (!coding_sublayer_reset_n) begin
      phyStatus <= 1'b0;
    end else if (sys_rst) begin
      phyStatus <= 1'b0;
    end else begin
      phyStatus <= setupEvent | pwrEvent | rateEvent | detectDone;
    end
  end

  always_ff @(posedge clk_sys or negedge coding_sublayer_reset_n) begin
    if (!coding_sublayer_reset_n) begin
      rdRun_reg <= 1'b0;
      errRun_reg <= '0;
      symLock_reg <= 1'b0;
    end else if (sys_rst) begin
      rdRun_reg <= 1'b0;
      errRun_reg <= '0;
      symLock_reg <= 1'b0;
    end else begin
      rdRun_reg <= rxPowered ? rdChain[4] : 1'b0;
      symLock_reg <= symLock_next;
      if (!symLock_reg || !anyCodeErr) begin
        errRun_reg <= '0;
      end else if (errRun_reg != LOCK_LOSS_WORDS) begin
        errRun_reg <= errRun_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge coding_sublayer_reset_n) begin
    if (!coding_sublayer_reset_n) begin
      rxData <= '0;
      rxDataK <= '0;
      rxValid <= 1'b0;
      rxStatus <= RXST_OK;
    end else if (sys_rst) begin
      rxData <= '0;
      rxDataK <= '0;
      rxValid <= 1'b0;
      rxStatus <= RXST_OK;
    end else begin
      // Soft mode hands raw symbols to the fabric, so the K flags carry nothing
      rxData <= softMode_reg ? rxWord : {8'h00, decBytes};
      rxDataK <= softMode_reg ? 4'h0 : decK;
      rxValid <= symLock_next;
      rxStatus <= rxStatus_next;
    end
  end

  always_ff @(posedge clk_sys or negedge coding_sublayer_reset_n) begin
    if (!coding_sublayer_reset_n) begin
      rxElecIdle <= 1'b1;
      rxStandbyStatus <= 1'b0;
    end else if (sys_rst) begin
      rxElecIdle <= 1'b1;
      rxStandbyStatus <= 1'b0;
    end else begin
      rxElecIdle <= (pwr_reg == PWR_P2) ? !beaconDetect : !signalDetect;
      rxStandbyStatus <= ctrl_reg.rxStandby;
    end
  end

  // Analog drive has its own reset so the serial side can be held while the coding logic runs
  always_ff @(posedge clk_sys or negedge medium_attach_reset_n) begin
    if (!medium_attach_reset_n) begin
      pmaDrive <= '0;
      pmaDrive.elecIdle <= 1'b1;
      pmaDrive.rxPowerDown <= 1'b1;
    end else if (sys_rst) begin
      pmaDrive <= '0;
      pmaDrive.elecIdle <= 1'b1;
      pmaDrive.rxPowerDown <= 1'b1;
    end else begin
      pmaDrive.gen2 <= ctrl_reg.rate == RATE_GEN2;
      pmaDrive.deemph6dB <= ctrl_reg.rate == RATE_GEN2 && !ctrl_reg.txDeemph;
      pmaDrive.halfSwing <= ctrl_reg.txSwing;
      pmaDrive.rxPowerDown <= !rxPowered;
      // P0s and P1 stay idle even if the MAC drops the idle request
      pmaDrive.elecIdle <= ctrl_reg.txElecIdle || pwr_reg == PWR_P0S || pwr_reg == PWR_P1;
      pmaDrive.beacon <= !ctrl_reg.txElecIdle && pwr_reg == PWR_P2;
      if (!ctrl_reg.txElecIdle && pwr_reg == PWR_P0) begin
        pmaDrive.data <= txData;
        pmaDrive.dataK <= txDataK;
      end else begin
        pmaDrive.data <= '0;
        pmaDrive.dataK <= '0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      softMode_reg <= CTRL_SOFT_RESET_VAL;
    end else if (write && !waitrequest && isAt(address, OFS_CTRL)) begin
      softMode_reg <= writedata[CTRL_SOFT_BIT];
    end
  end

  // A counted error in the clearing cycle survives as a count of one
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      errCnt_reg <= '0;
    end else if (symLock_reg && (anyCodeErr || anyDispErr)) begin
      errCnt_reg <= errClear ? 16'h0001 : (errCnt_reg == 16'hffff ? errCnt_reg : errCnt_reg + 1'b1);
    end else if (errClear) begin
      errCnt_reg <= '0;
    end
  end

  always_comb begin
    statusWord = '0;
    statusWord[ST_PWR_LSB +: 2] = pwr_reg;
    statusWord[ST_RATE_LSB +: 2] = ctrl_reg.rate;
    statusWord[ST_STANDBY_BIT] = rxStandbyStatus;
    statusWord[ST_LOCK_BIT] = symLock_reg;
    statusWord[ST_IDLE_BIT] = rxElecIdle;
    statusWord[ST_CDR_BIT] = cdrLock;
    statusWord[ST_SETUP_BIT] = setupDone_reg;
  end

  // A request that follows an idle edge is answered on the second edge: waitrequest drops for exactly one cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      waitrequest <= 1'b1;
      readdata <= '0;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      if (isAt(address, OFS_CTRL)) begin
        readdata <= {31'h0, softMode_reg};
      end else if (isAt(address, OFS_STATUS)) begin
        readdata <= statusWord;
      end else if (isAt(address, OFS_ERRCNT)) begin
        readdata <= {16'h0000, errCnt_reg};
      end else begin
        readdata <= '0;
      end
    end else begin
      waitrequest <= 1'b1;
    end
  end
endmodule // pipe_lane_phy

// file: rtl/pipe_lane_pkg.sv
package pipe_lane_pkg;
  localparam int CLK_FREQ_MHZ = 50;
  localparam int SETUP_TIME_NS = 2000;
  localparam int SETUP_CYCLES = (SETUP_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int DETECT_TIME_NS = 400;
  localparam int DETECT_CYCLES = (DETECT_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam logic [2:0] LOCK_LOSS_WORDS = 3'h4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_ERRCNT = 4'h8;
  localparam logic CTRL_SOFT_RESET_VAL = 1'b0;
  localparam int CTRL_SOFT_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int ST_PWR_LSB = 0;
  localparam int ST_RATE_LSB = 2;
  localparam int ST_STANDBY_BIT = 4;
  localparam int ST_LOCK_BIT = 5;
  localparam int ST_IDLE_BIT = 6;
  localparam int ST_CDR_BIT = 7;
  localparam int ST_SETUP_BIT = 8;
  localparam logic [2:0] RXST_OK = 3'h0;
  localparam logic [2:0] RXST_SKP_ADD = 3'h1;
  localparam logic [2:0] RXST_SKP_REM = 3'h2;
  localparam logic [2:0] RXST_DETECTED = 3'h3;
  localparam logic [2:0] RXST_CODE_ERR = 3'h4;
  localparam logic [2:0] RXST_OVERFLOW = 3'h5;
  localparam logic [2:0] RXST_UNDERFLOW = 3'h6;
  localparam logic [2:0] RXST_DISP_ERR = 3'h7;
  localparam logic [1:0] RATE_GEN2 = 2'h1;
  localparam logic [5:0] SIX_K28_NEG = 6'h0f;
  localparam logic [5:0] SIX_K28_POS = 6'h30;
  localparam logic [7:0] COMMA_BYTE = 8'hbc;
  typedef enum logic [1:0] {PWR_P0, PWR_P0S, PWR_P1, PWR_P2} power_state_t;
  typedef struct packed {
    logic txDeemph;
    logic txSwing;
    logic rxPolarity;
    logic rxStandby;
    logic txElecIdle;
    logic txDetectRx;
    logic [1:0] rate;
  } pipe_ctrl_t;
  typedef struct packed {
    logic elecIdle;
    logic beacon;
    logic halfSwing;
    logic deemph6dB;
    logic gen2;
    logic rxPowerDown;
    logic [3:0] dataK;
    logic [39:0] data;
  } pma_drive_t;
  typedef struct packed {
    logic skpAdded;
    logic skpRemoved;
    logic overflow;
    logic underflow;
  } eb_event_t;
endpackage

// file: rtl/sym_decoder_8b10b.sv
`timescale 1ns/100ps
module sym_decoder_8b10b import pipe_lane_pkg::*; (
  input wire logic [9:0] sym,
  input wire logic rdIn,
  output logic [7:0] dataByte,
  output logic isK,
  output logic codeErr,
  output logic dispErr,
  output logic rdOut
);
  logic [5:0] six;
  logic [3:0] four;
  logic [4:0] x;
  logic [2:0] y;
  logic bad6;
  logic bad4;
  logic [3:0] ones;
  always_comb begin
    six = {sym[0], sym[1], sym[2], sym[3], sym[4], sym[5]};
    four = {sym[6], sym[7], sym[8], sym[9]};
    // K28 in its positive form carries the complemented minor subblock
    if (six == SIX_K28_POS) four = ~four;
    bad6 = 1'b0;
    unique case (six)
      6'h27, 6'h18: x = 5'h00;
      6'h1d, 6'h22: x = 5'h01;
      6'h2d, 6'h12: x = 5'h02;
      6'h31: x = 5'h03;
      6'h35, 6'h0a: x = 5'h04;
      6'h29: x = 5'h05;
      6'h19: x = 5'h06;
      6'h38, 6'h07: x = 5'h07;
      6'h39, 6'h06: x = 5'h08;
      6'h25: x = 5'h09;
      6'h15: x = 5'h0a;
      6'h34: x = 5'h0b;
      6'h0d: x = 5'h0c;
      6'h2c: x = 5'h0d;
      6'h1c: x = 5'h0e;
      6'h17, 6'h28: x = 5'h0f;
      6'h1b, 6'h24: x = 5'h10;
      6'h23: x = 5'h11;
      6'h13: x = 5'h12;
      6'h32: x = 5'h13;
      6'h0b: x = 5'h14;
      6'h2a: x = 5'h15;
      6'h1a: x = 5'h16;
      6'h3a, 6'h05: x = 5'h17;
      6'h33, 6'h0c: x = 5'h18;
      6'h26: x = 5'h19;
      6'h16: x = 5'h1a;
      6'h36, 6'h09: x = 5'h1b;
      6'h0e, 6'h0f, 6'h30: x = 5'h1c;
      6'h2e, 6'h11: x = 5'h1d;
      6'h1e, 6'h21: x = 5'h1e;
      6'h2b, 6'h14: x = 5'h1f;
      default: begin
        x = 5'h00;
        bad6 = 1'b1;
      end
    endcase
    bad4 = 1'b0;
    unique case (four)
      4'hb, 4'h4: y = 3'h0;
      4'h9: y = 3'h1;
      4'h5: y = 3'h2;
      4'hc, 4'h3: y = 3'h3;
      4'hd, 4'h2: y = 3'h4;
      4'ha: y = 3'h5;
      4'h6: y = 3'h6;
      4'he, 4'h1, 4'h7, 4'h8: y = 3'h7;
      default: begin
        y = 3'h0;
        bad4 = 1'b1;
      end
    endcase
    ones = 4'($countones(sym));
    dataByte = {y, x};
    isK = (six == SIX_K28_NEG) || (six == SIX_K28_POS) || ((four == 4'h7 || four == 4'h8) &&
          (x == 5'h17 || x == 5'h1b || x == 5'h1d || x == 5'h1e));
    codeErr = bad6 || bad4 || ones < 4'h4 || ones > 4'h6;
    // Subblock disparity is not checked; only the running disparity of whole symbols
    dispErr = (ones == 4'h6 && rdIn) || (ones == 4'h4 && !rdIn);
    rdOut = (ones == 4'h6) ? 1'b1 : (ones == 4'h4) ? 1'b0 : rdIn;
  end
endmodule // sym_decoder_8b10b

// file: testbench/mac_link_model.sv
`timescale 1ns/100ps
module mac_link_model import pipe_lane_pkg::*; (
  input wire logic clk_sys,
  input wire pipe_ctrl_t ctrlReq,
  input wire logic [1:0] powerReq,
  output pipe_ctrl_t pipeCtrl,
  output logic [1:0] power_state_select
);
  // Requests pass through one register so that every control moves just after an edge
  always_ff @(posedge clk_sys) begin
    power_state_select <= powerReq;
    pipeCtrl <= ctrlReq;
    pipeCtrl.rate <= {1'b0, ctrlReq.rate[0]};
    // A real link layer never asks for data while the lane is in P0s or P1
    if (powerReq == PWR_P0S || powerReq == PWR_P1) begin
      pipeCtrl.txElecIdle <= 1'b1;
    end
  end
endmodule // mac_link_model

// file: testbench/pipe_lane_phy_sva.sv
`timescale 1ns/100ps
module pipe_lane_phy_sva import pipe_lane_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic coding_sublayer_reset_n,
  input wire logic medium_attach_reset_n,
  input wire pipe_ctrl_t pipeCtrl,
  input wire logic [1:0] power_state_select,
  input wire logic cdrLock,
  input wire logic beaconDetect,
  input wire logic rxdP,
  input wire logic rxdN,
  input wire pma_drive_t pmaDrive,
  input wire logic rxValid,
  input wire logic [2:0] rxStatus,
  input wire logic rxElecIdle,
  input wire logic rxStandbyStatus,
  input wire logic phyStatus,
  input wire logic rxBypassData
);
  logic [1:0] upCnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst || !coding_sublayer_reset_n || !medium_attach_reset_n);
  // Two-deep history must not reach back into a reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !coding_sublayer_reset_n || !medium_attach_reset_n) upCnt <= 2'h0;
    else if (upCnt != 2'h3) upCnt <= upCnt + 2'h1;
  end
  AST_SWING: assert property (upCnt == 2'h3 |-> pmaDrive.halfSwing == $past(pipeCtrl.txSwing, 2))
    else $error("swing select not followed");
  AST_DEEMPH: assert property (upCnt == 2'h3 && $past(pipeCtrl.rate, 2) == RATE_GEN2 |->
    pmaDrive.gen2 && pmaDrive.deemph6dB == !$past(pipeCtrl.txDeemph, 2)) else $error("de-emphasis wrong");
  AST_TX_IDLE: assert property (upCnt == 2'h3 && ($past(pipeCtrl.txElecIdle, 2) ||
    $past(power_state_select, 2) inside {PWR_P0S, PWR_P1}) |-> pmaDrive.elecIdle && !pmaDrive.beacon)
    else $error("transmitter not idle");
  AST_BEACON: assert property (upCnt == 2'h3 && $past(power_state_select, 2) == PWR_P2 &&
    !$past(pipeCtrl.txElecIdle, 2) |-> pmaDrive.beacon) else $error("beacon missing");
  AST_STANDBY: assert property (upCnt == 2'h3 |-> rxStandbyStatus == $past(pipeCtrl.rxStandby, 2))
    else $error("standby status wrong");
  AST_LOCK_LOSS: assert property ((!cdrLock) [*3] |-> !rxValid) else $error("valid without lock");
  AST_RX_BEACON: assert property ((power_state_select == PWR_P2 && beaconDetect) [*3] |-> !rxElecIdle)
    else $error("beacon not reported");
  AST_BYPASS: assert property (rxBypassData == (rxdP & ~rxdN)) else $error("bypass mismatch");
  AST_PHY_PULSE: assert property (phyStatus |=> !phyStatus) else $error("status pulse too long");
  AST_RST_PMA: assert property (disable iff (1'b0) !medium_attach_reset_n |->
    pmaDrive.elecIdle && pmaDrive.rxPowerDown && !pmaDrive.beacon) else $error("pma not reset");
  AST_RST_PCS: assert property (disable iff (1'b0) !coding_sublayer_reset_n |->
    !rxValid && !phyStatus && rxElecIdle) else $error("pcs not reset");
  COV_LOCK: cover property ($rose(rxValid));
  COV_DETECT: cover property (phyStatus && rxStatus == RXST_DETECTED);
  COV_BEACON: cover property (pmaDrive.beacon);
endmodule // pipe_lane_phy_sva
bind pipe_lane_phy pipe_lane_phy_sva chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .coding_sublayer_reset_n(coding_sublayer_reset_n), .medium_attach_reset_n(medium_attach_reset_n),
  .pipeCtrl(pipeCtrl), .power_state_select(power_state_select), .cdrLock(cdrLock),
  .beaconDetect(beaconDetect), .rxdP(rxdP), .rxdN(rxdN), .pmaDrive(pmaDrive), .rxValid(rxValid),
  .rxStatus(rxStatus), .rxElecIdle(rxElecIdle), .rxStandbyStatus(rxStandbyStatus),
  .phyStatus(phyStatus), .rxBypassData(rxBypassData));

// file: testbench/pipe_lane_phy_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin errTotal++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, a); end end
module pipe_lane_phy_tb_top import pipe_lane_pkg::*; ;
  logic clk_sys, sys_rst, pcsRstN, pmaRstN, read, write, waitrequest, cdrLock, signalDetect;
  logic beaconDetect, farEnd, rxdP, rxdN, rxValid, rxElecIdle, rxStandbyStatus, phyStatus, rxBypassData;
  logic [3:0] address, txDataK, rxDataK;
  logic [31:0] writedata, readdata, rd;
  logic [39:0] txData, pmaRxWord, rxData;
  logic [2:0] rxStatus;
  logic [1:0] pss, powerReq;
  pipe_ctrl_t pipeCtrl, ctrlReq;
  eb_event_t ebEvent;
  pma_drive_t pmaDrive;
  int errTotal, checked, n, p, i;
  // Four commas, then comma/data mix; both end on negative running disparity so they repeat cleanly
  localparam logic [39:0] LOCK_WORD = {10'h283, 10'h17c, 10'h283, 10'h17c};
  localparam logic [39:0] MIX_WORD = {10'h0b9, 10'h283, 10'h346, 10'h17c};
  eb_event_t evs[4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  logic [2:0] codes[4] = '{RXST_SKP_ADD, RXST_SKP_REM, RXST_OVERFLOW, RXST_UNDERFLOW};

  mac_link_model mac_u (.clk_sys(clk_sys), .ctrlReq(ctrlReq), .powerReq(powerReq), .pipeCtrl(pipeCtrl),
    .power_state_select(pss));
  pipe_lane_phy dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .coding_sublayer_reset_n(pcsRstN),
    .medium_attach_reset_n(pmaRstN), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .pipeCtrl(pipeCtrl), .power_state_select(pss),
    .txData(txData), .txDataK(txDataK), .pmaRxWord(pmaRxWord), .cdrLock(cdrLock), .signalDetect(signalDetect),
    .beaconDetect(beaconDetect), .farEndDetected(farEnd), .ebEvent(ebEvent), .rxdP(rxdP), .rxdN(rxdN),
    .pmaDrive(pmaDrive), .rxData(rxData), .rxDataK(rxDataK), .rxValid(rxValid), .rxStatus(rxStatus),
    .rxElecIdle(rxElecIdle), .rxStandbyStatus(rxStandbyStatus), .phyStatus(phyStatus),
    .rxBypassData(rxBypassData));

  always #10 clk_sys = ~clk_sys;

  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic waitPhy;
    for (n = 0; n < 300; n++) begin
      @(posedge clk_sys);
      if (phyStatus === 1'b1) break;
    end
    if (n == 300) begin errTotal++; results(); end
  endtask

  // Request held until waitrequest is seen low, then released with one idle edge after it
  task automatic busAcc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    address <= a;
    writedata <= d;
    if (wr) write <= 1'b1;
    else read <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (waitrequest === 1'b0) break;
    end
    if (k == 50) begin errTotal++; results(); end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 0; sys_rst = 1; pcsRstN = 1; pmaRstN = 1; read = 0; write = 0; address = '0; writedata = '0;
    cdrLock = 0; signalDetect = 0; beaconDetect = 1; farEnd = 0; rxdP = 0; rxdN = 1; ebEvent = '0;
    txData = 40'h5a_1234_abcd; txDataK = 4'h9; pmaRxWord = LOCK_WORD; ctrlReq = '0; powerReq = 2'h0;
    errTotal = 0; checked = 0;
    cyc(12);
    sys_rst <= 1'b0;
    waitPhy();
    busAcc(0, OFS_STATUS, 0); `CHK("setup", 1'b1, rd[ST_SETUP_BIT])
    busAcc(0, 4'hc, 0); `CHK("unmapped", 32'h0, rd)
    for (p = 0; p < 4; p++) for (i = 0; i < 2; i++) begin
      ctrlReq.txElecIdle <= i[0];
      powerReq <= p[1:0];
      cyc(6);
      `CHK("txIdle", 1'(i == 1 || p == 1 || p == 2), pmaDrive.elecIdle)
      `CHK("beacon", 1'(p == 3 && i == 0), pmaDrive.beacon)
      `CHK("txWord", (p == 0 && i == 0) ? {txDataK, txData} : 44'h0, {pmaDrive.dataK, pmaDrive.data})
      `CHK("rxIdle", 1'(p != 3), rxElecIdle)
    end
    ctrlReq.txElecIdle <= 1'b0; ctrlReq.txSwing <= 1'b1; ctrlReq.rate <= 2'h1; powerReq <= 2'h0;
    cyc(6);
    `CHK("halfSwing", 1'b1, pmaDrive.halfSwing)
    `CHK("deemph6", 1'b1, pmaDrive.deemph6dB)
    ctrlReq.txDeemph <= 1'b1;
    cyc(6);
    `CHK("deemph35", 1'b0, pmaDrive.deemph6dB)
    cdrLock <= 1'b1; signalDetect <= 1'b1;
    cyc(6);
    `CHK("rxValid", 1'b1, rxValid)
    `CHK("rxCommas", 40'h00_bcbc_bcbc, rxData)
    `CHK("rxCommaK", 4'hf, rxDataK)
    `CHK("rxOk", RXST_OK, rxStatus)
    pmaRxWord <= MIX_WORD;
    cyc(3);
    `CHK("byteOrder", 40'h00_00bc_00bc, rxData)
    `CHK("mixK", 4'h5, rxDataK)
    for (p = 0; p < 4; p++) begin
      ebEvent <= evs[p];
      @(posedge clk_sys);
      ebEvent <= '0;
      // Status stands for one word only, so it is read at the very next edge
      @(posedge clk_sys);
      `CHK("ebStatus", codes[p], rxStatus)
    end
    ctrlReq.rxStandby <= 1'b1;
    cyc(6);
    `CHK("standby", 1'b1, rxStandbyStatus)
    `CHK("validStandby", 1'b0, rxValid)
    `CHK("rxPwrDown", 1'b1, pmaDrive.rxPowerDown)
    `CHK("gen2", 1'b1, pmaDrive.gen2)
    ctrlReq.rxStandby <= 1'b0;
    cyc(6);
    `CHK("active", 1'b0, rxStandbyStatus)
    `CHK("relock", 1'b1, rxValid)
    pmaRxWord <= 40'h0;
    @(posedge clk_sys);
    pmaRxWord <= MIX_WORD; cdrLock <= 1'b0;
    @(posedge clk_sys);
    `CHK("codeErr", RXST_CODE_ERR, rxStatus)
    busAcc(0, OFS_ERRCNT, 0); `CHK("errSeen", 1'b1, 1'(rd[15:0] != 16'h0))
    busAcc(1, OFS_CTRL, 32'h2);
    busAcc(0, OFS_ERRCNT, 0); `CHK("errClr", 32'h0, rd)
    busAcc(1, OFS_CTRL, 32'h1);
    busAcc(0, OFS_CTRL, 0); `CHK("ctrl", 32'h1, rd)
    ctrlReq.rxPolarity <= 1'b1;
    cyc(6);
    `CHK("softInv", ~MIX_WORD, rxData)
    `CHK("softK", 4'h0, rxDataK)
    ctrlReq.rxPolarity <= 1'b0;
    cyc(6);
    `CHK("softRaw", MIX_WORD, rxData)
    busAcc(1, OFS_CTRL, 32'h0);
    powerReq <= PWR_P1;
    waitPhy();
    for (p = 1; p >= 0; p--) begin
      farEnd <= p[0];
      ctrlReq.txDetectRx <= 1'b1;
      waitPhy();
      `CHK("detect", p ? RXST_DETECTED : RXST_OK, rxStatus)
      ctrlReq.txDetectRx <= 1'b0;
      cyc(3);
    end
    rxdP <= 1'b1; rxdN <= 1'b0;
    @(posedge clk_sys);
    `CHK("bypassHi", 1'b1, rxBypassData)
    rxdP <= 1'b0; rxdN <= 1'b1;
    @(posedge clk_sys);
    `CHK("bypassLo", 1'b0, rxBypassData)
    powerReq <= PWR_P0;
    cyc(6);
    pmaRstN <= 1'b0;
    cyc(2);
    `CHK("pmaRst", 1'b1, pmaDrive.elecIdle)
    `CHK("pcsKept", 1'b0, rxElecIdle)
    pmaRstN <= 1'b1;
    pcsRstN <= 1'b0;
    cyc(2);
    `CHK("pcsRst", 2'b10, {rxElecIdle, rxValid})
    pcsRstN <= 1'b1;
    waitPhy();
    results();
  end
endmodule // pipe_lane_phy_tb_top
